// file: core/p3mc_pkg.sv
package p3mc_pkg;
  localparam logic [7:0] P3MC_ADDR       = 8'hF7;
  localparam int         P3MC_BIT_P2PP   = 0;
  localparam int         P3MC_BIT_ANALOG = 1;
  localparam int         P3MC_BIT_IRAMP  = 2;
  localparam logic [2:0] P3MC_RESET      = 3'h0;
  localparam logic [4:0] P3MC_RSVD_READ  = 5'h1F;
endpackage

// file: core/p3mc_route.sv
`timescale 1ns/10ps
`default_nettype none
// combinational pin routing from the three control bits
module p3mc_route
  import p3mc_pkg::*;
(
  // control
  input  wire logic [2:0] ctrl,
  // routing
  output logic [3:0]      digitalEn,
  output logic [3:0]      compEn,
  output logic            irampSel,
  output logic            irampPinEn,
  output logic            port2PushPull
);
  always_comb
  begin
    digitalEn     = ctrl[P3MC_BIT_ANALOG] ? 4'h0 : 4'hF;
    compEn        = ctrl[P3MC_BIT_ANALOG] ? 4'hD : 4'h0;
    irampPinEn    = ctrl[P3MC_BIT_ANALOG] & ctrl[P3MC_BIT_IRAMP];
    if (ctrl[P3MC_BIT_ANALOG] && !ctrl[P3MC_BIT_IRAMP])
    begin
      compEn[1] = 1'b1;
    end
    irampSel      = ctrl[P3MC_BIT_IRAMP];
    port2PushPull = ctrl[P3MC_BIT_P2PP];
  end
endmodule
`default_nettype wire

// file: core/p3mc_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module p3mc_top
  import p3mc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic [7:0]      regRdata,
  // stop-mode recovery event, has no effect on this register
  input  wire logic       stopRecover,
  // pin routing
  output logic [3:0]      pinDigitalEn,
  output logic [3:0]      pinCompEn,
  output logic            firstCompIrSel,
  output logic            irampPinEn,
  output logic            port2PushPull
);
  logic [2:0] ctrl_q;
  logic [3:0] digD;
  logic [3:0] compD;
  logic       irD;
  logic       irPinD;
  logic       ppD;
  logic       hit;

  assign hit = (regAddr == P3MC_ADDR);

  // stopRecover deliberately not in the sensitivity of any state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_q <= P3MC_RESET;
    else if (regWr && hit)
      ctrl_q <= regWdata[2:0];
  end

  // write-only control bits read back as zero; reserved read as ones
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      regRdata <= 8'h00;
    else if (regRd && hit)
      regRdata <= {P3MC_RSVD_READ, 3'h0};
    else
      regRdata <= 8'h00;
  end

  p3mc_route u_route (
    .ctrl          (ctrl_q),
    .digitalEn     (digD),
    .compEn        (compD),
    .irampSel      (irD),
    .irampPinEn    (irPinD),
    .port2PushPull (ppD)
  );

  // registered so every output comes from a flop; one cycle after the register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pinDigitalEn   <= 4'hF;
      pinCompEn      <= 4'h0;
      firstCompIrSel <= 1'b0;
      irampPinEn     <= 1'b0;
      port2PushPull  <= 1'b0;
    end
    else
    begin
      pinDigitalEn   <= digD;
      pinCompEn      <= compD;
      firstCompIrSel <= irD;
      irampPinEn     <= irPinD;
      port2PushPull  <= ppD;
    end
  end

  property p_ir_sel;
    @(posedge mclk) disable iff (rst)
    ctrl_q[P3MC_BIT_IRAMP] |=> firstCompIrSel;
  endproperty
  a_ir_sel: assert property (p_ir_sel) else $error("ir select lost");

  property p_digital;
    @(posedge mclk) disable iff (rst)
    !ctrl_q[P3MC_BIT_ANALOG] |=> (pinDigitalEn == 4'hF) && (pinCompEn == 4'h0);
  endproperty
  a_digital: assert property (p_digital) else $error("digital mode wrong");

  property p_comp;
    @(posedge mclk) disable iff (rst)
    (ctrl_q[P3MC_BIT_ANALOG] && !ctrl_q[P3MC_BIT_IRAMP]) |=> pinCompEn == 4'hF;
  endproperty
  a_comp: assert property (p_comp) else $error("comparator pins wrong");

  property p_irpin;
    @(posedge mclk) disable iff (rst)
    (ctrl_q[P3MC_BIT_ANALOG] && ctrl_q[P3MC_BIT_IRAMP])
      |=> irampPinEn && (pinCompEn == 4'hD);
  endproperty
  a_irpin: assert property (p_irpin) else $error("ir pin wrong");

  sequence s_write_pp;
    regWr && hit && regWdata[P3MC_BIT_P2PP];
  endsequence
  property p_pp;
    @(posedge mclk) disable iff (rst)
    s_write_pp ##1 !(regWr && hit) |=> port2PushPull;
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull not set");

  property p_keep;
    @(posedge mclk) disable iff (rst)
    (stopRecover && !(regWr && hit)) |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_keep: assert property (p_keep) else $error("stop recovery changed reg");

  property p_decode;
    @(posedge mclk) disable iff (rst)
    (regWr && !hit) |=> $stable(ctrl_q);
  endproperty
  a_decode: assert property (p_decode) else $error("foreign address wrote");

  property p_rsvd;
    @(posedge mclk) disable iff (rst)
    (regRd && hit) |=> regRdata == 8'hF8;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved readback wrong");

  // the checks below pin each output to the register in both directions,
  // so a stuck-high or stuck-low routing bit cannot hide behind one case

  property p_ir_clr;
    @(posedge mclk) disable iff (rst)
    !ctrl_q[P3MC_BIT_IRAMP] |=> !firstCompIrSel;
  endproperty
  a_ir_clr: assert property (p_ir_clr) else $error("ir select stuck");

  // the amplifier takes over even with the pins left digital
  property p_ir_over;
    @(posedge mclk) disable iff (rst)
    (ctrl_q[P3MC_BIT_IRAMP] && !ctrl_q[P3MC_BIT_ANALOG])
      |=> firstCompIrSel && (pinDigitalEn == 4'hF);
  endproperty
  a_ir_over: assert property (p_ir_over) else $error("ir override wrong");

  property p_analog_off;
    @(posedge mclk) disable iff (rst)
    ctrl_q[P3MC_BIT_ANALOG] |=> pinDigitalEn == 4'h0;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("digital left on");

  property p_comp_fixed;
    @(posedge mclk) disable iff (rst)
    ctrl_q[P3MC_BIT_ANALOG] |=> pinCompEn[0] && pinCompEn[2] && pinCompEn[3];
  endproperty
  a_comp_fixed: assert property (p_comp_fixed) else $error("fixed comparator off");

  property p_irpin_off;
    @(posedge mclk) disable iff (rst)
    !(ctrl_q[P3MC_BIT_ANALOG] && ctrl_q[P3MC_BIT_IRAMP]) |=> !irampPinEn;
  endproperty
  a_irpin_off: assert property (p_irpin_off) else $error("ir pin stuck");

  property p_pp_follow;
    @(posedge mclk) disable iff (rst)
    ctrl_q[P3MC_BIT_P2PP] |=> port2PushPull;
  endproperty
  a_pp_follow: assert property (p_pp_follow) else $error("push-pull lost");

  property p_pp_clr;
    @(posedge mclk) disable iff (rst)
    !ctrl_q[P3MC_BIT_P2PP] |=> !port2PushPull;
  endproperty
  a_pp_clr: assert property (p_pp_clr) else $error("open-drain lost");

  sequence s_write_hit;
    regWr && hit;
  endsequence

  property p_write_lands;
    @(posedge mclk) disable iff (rst)
    s_write_hit |=> ctrl_q == $past(regWdata[2:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_idle_keep;
    @(posedge mclk) disable iff (rst)
    !(regWr && hit) |=> $stable(ctrl_q);
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("register drifted");

  property p_rd_foreign;
    @(posedge mclk) disable iff (rst)
    (regRd && !hit) |=> regRdata == 8'h00;
  endproperty
  a_rd_foreign: assert property (p_rd_foreign) else $error("foreign read answered");

  // read data must not linger, or a later poll sees a stale byte
  property p_rd_idle;
    @(posedge mclk) disable iff (rst)
    !(regRd && hit) |=> regRdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data lingered");

  property p_both_off;
    @(posedge mclk) disable iff (rst)
    !ctrl_q[P3MC_BIT_ANALOG] |=> !irampPinEn && (pinDigitalEn == 4'hF);
  endproperty
  a_both_off: assert property (p_both_off) else $error("digital pins lost");
endmodule
`default_nettype wire

// file: bench/p3mc_pins.sv
`timescale 1ns/10ps
`default_nettype none
// far-side pins: a pin claimed twice would fight
module p3mc_pins
(
  // enables from the block
  input  wire logic [3:0] digEn,
  input  wire logic [3:0] cmpEn,
  input  wire logic       irPin,
  // fault flag
  output logic            clash
);
  assign clash = |(digEn & cmpEn) | (irPin & cmpEn[1]);
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import p3mc_pkg::*;
  logic       mclk = 0, rst = 1, regWr = 0, regRd = 0, stopRecover = 0, clash;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [3:0] pinDigitalEn, pinCompEn;
  logic       firstCompIrSel, irampPinEn, port2PushPull;
  int         nErrors = 0, comparisons = 0, cyc = 0;
  always #50 mclk = ~mclk;
  p3mc_top dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .stopRecover(stopRecover),
    .pinDigitalEn(pinDigitalEn), .pinCompEn(pinCompEn), .firstCompIrSel(firstCompIrSel),
    .irampPinEn(irampPinEn), .port2PushPull(port2PushPull));
  p3mc_pins pins_u (.digEn(pinDigitalEn), .cmpEn(pinCompEn), .irPin(irampPinEn),
    .clash(clash));
  task automatic close_out;
    $display("checks %0d errors %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk("regRdata", exp, regRdata);
  endtask
  // outputs settle one edge after the write edge; checked two edges after it
  task automatic pinChk(input logic [2:0] c);
    repeat (2) @(posedge mclk);
    #1 chk("pins", c[1] ? {4'h0, c[2] ? 4'hD : 4'hF} : 8'hF0, {pinDigitalEn, pinCompEn});
    chk("modes", {5'h00, c[2], c[1] & c[2], c[0]},
      {4'h0, clash, firstCompIrSel, irampPinEn, port2PushPull});
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 500)
    begin
      nErrors++;
      close_out;
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    pinChk(3'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(P3MC_ADDR, {5'h1F, i[2:0]});
      pinChk(i[2:0]);
    end
    $display("test modes done");
    rdChk(P3MC_ADDR, {P3MC_RSVD_READ, 3'h0});
    wr(8'hF6, 8'h00);
    rdChk(8'hF6, 8'h00);
    @(posedge mclk);
    stopRecover <= 1'b1;
    @(posedge mclk);
    stopRecover <= 1'b0;
    pinChk(3'h7);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    pinChk(3'h0);
    $display("test keep and reset done");
    close_out;
  end
endmodule
`default_nettype wire
